// File: verilog/cpt_pkg.sv
// package: register map, field layout and shared types of the can pin and priority block
package cpt_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PIN_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_TX_PRIO     = 8'h04;
  localparam logic [7:0] ADDR_TX_REQ      = 8'h08;
  localparam logic [7:0] ADDR_SELECT      = 8'h0c;
  localparam logic [7:0] ADDR_LENGTH      = 8'h10;
  localparam logic [7:0] ADDR_MODE        = 8'h14;

  // ---------------------------------------------------------------
  // pin control fields
  // ---------------------------------------------------------------
  localparam int         BIT_SECOND_TX_SOURCE_SEL = 7;
  localparam int         BIT_SECOND_TX_PIN_ENABLE = 6;
  localparam int         BIT_RECESSIVE_DRIVE_HIGH = 5;
  localparam int         BIT_RX_CAPTURE_ROUTE     = 4;
  localparam int         BIT_CAN_CLOCK_SOURCE_SEL = 0;
  localparam logic [7:0] PIN_CONTROL_MASK         = 8'hf1;
  localparam logic [7:0] PIN_CONTROL_RESET        = 8'h00;

  // ---------------------------------------------------------------
  // length code and mode
  // ---------------------------------------------------------------
  localparam logic [3:0] LENGTH_CODE_MAX   = 4'h8;
  localparam logic [1:0] MODE_LEGACY       = 2'h0;
  localparam logic [1:0] MODE_ENHANCED     = 2'h1;
  localparam logic [1:0] MODE_FIFO         = 2'h2;
  localparam logic [1:0] MODE_RESET        = 2'h0;
  localparam int         NUM_BUFFERS       = 8;
  localparam int         BUF_IDX_W         = 3;

  // ---------------------------------------------------------------
  // bus response codes
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic second_tx_source_sel;
    logic second_tx_pin_enable;
    logic recessive_drive_high;
    logic rx_capture_route;
    logic can_clock_source_sel;
  } cpt_pin_ctrl_t;

  typedef struct packed {
    logic [3:0] byte_count;
    logic       valid;
  } cpt_length_t;

  typedef struct packed {
    logic       found;
    logic [2:0] index;
  } cpt_pick_t;

endpackage

// File: verilog/cpt_length_decode.sv
// length code decoder: four-bit code to byte count with a validity flag
`timescale 1ns/1ns
module cpt_length_decode (
  // code in
  input  wire logic [3:0]          i_length_code,
  // decoded
  output cpt_pkg::cpt_length_t     o_length
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  always_comb begin
    if (i_length_code <= cpt_pkg::LENGTH_CODE_MAX) begin
      o_length.byte_count = i_length_code;
      o_length.valid      = 1'b1;
    end else begin
      o_length.byte_count = 4'h0;
      o_length.valid      = 1'b0;
    end
  end

endmodule // cpt_length_decode

// File: verilog/cpt_prio_pick.sv
// priority picker: highest level wins, larger buffer number breaks ties
`timescale 1ns/1ns
module cpt_prio_pick #(
  parameter int N = 8
) (
  // requests and levels
  input  wire logic [N-1:0]        i_req,
  input  wire logic [2*N-1:0]      i_prio,
  // winner
  output cpt_pkg::cpt_pick_t       o_pick
);

  if (N < 1 || N > 8) begin : g_n_bad
    $error("cpt_prio_pick: N must be 1 to 8");
  end

  // ---------------------------------------------------------------
  // scan, later index wins on equal level
  // ---------------------------------------------------------------
  always_comb begin
    logic [1:0] best;
    best          = 2'h0;
    o_pick.found  = 1'b0;
    o_pick.index  = 3'h0;
    for (int k = 0; k < N; k++) begin
      if (i_req[k]) begin
        if (!o_pick.found || i_prio[2*k +: 2] >= best) begin
          best         = i_prio[2*k +: 2];
          o_pick.found = 1'b1;
          o_pick.index = 3'(k);
        end
      end
    end
  end

endmodule // cpt_prio_pick

// File: verilog/cpt_top.sv
// top: can pin control, transmit priority selection, length decode, axi4-lite slave
// What this block does
// - codes zero to eight give that byte count
// - code eight is eight bytes; above reserved
// - length view only in modes one and two
// - source bit picks can clock or inverted tx
// - enable bit drives second pin, else i/o
// - drive-high bit drives recessive high, else float
// - capture bit routes receive signal to capture
// - clock-select bit picks oscillator or pll
// - before start of frame, pick highest priority
// - equal priority: largest buffer number wins
// - two-bit level, eleven highest, zero lowest
// - selection never touches bus arbitration
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
module cpt_top #(
  parameter int NUM_BUF = cpt_pkg::NUM_BUFFERS
) (
  // clock, reset, enable
  input  wire logic                i_ref_clk,
  input  wire logic                i_arst_n,
  input  wire logic                i_clk_en,
  // axi4-lite write address
  input  wire logic [7:0]          i_awaddr,
  input  wire logic                i_awvalid,
  output logic                     o_awready,
  // axi4-lite write data
  input  wire logic [31:0]         i_wdata,
  input  wire logic [3:0]          i_wstrb,
  input  wire logic                i_wvalid,
  output logic                     o_wready,
  // axi4-lite write response
  output logic [1:0]               o_bresp,
  output logic                     o_bvalid,
  input  wire logic                i_bready,
  // axi4-lite read address
  input  wire logic [7:0]          i_araddr,
  input  wire logic                i_arvalid,
  output logic                     o_arready,
  // axi4-lite read data
  output logic [31:0]              o_rdata,
  output logic [1:0]               o_rresp,
  output logic                     o_rvalid,
  input  wire logic                i_rready,
  // frame engine
  input  wire logic                i_sof_req,
  input  wire logic                i_tx_done,
  output logic                     o_sel_valid,
  output logic [2:0]               o_sel_index,
  input  wire logic                i_core_tx,
  input  wire logic                i_rx_msg,
  input  wire logic [3:0]          i_rx_length_code,
  input  wire logic                i_rx_rtr,
  // clocks
  input  wire logic                i_osc_clk,
  input  wire logic                i_pll_clk,
  output logic                     o_can_clk,
  // pins
  output logic                     o_tx_pin,
  output logic                     o_tx_pin_oe_n,
  output logic                     o_second_tx_pin,
  output logic                     o_second_tx_pin_oe_n,
  output logic                     o_second_tx_pin_is_can,
  input  wire logic                i_shared_port_pin,
  output logic                     o_capture_unit_one_in
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (NUM_BUF < 1 || NUM_BUF > 8) begin : g_num_buf_bad
    $error("cpt_top: NUM_BUF must be 1 to 8");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]         pin_control;
    logic [15:0]        tx_prio;
    logic [7:0]         tx_req;
    logic [1:0]         mode;
    logic               aw_held;
    logic [7:0]         aw_addr;
    logic               w_held;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic               sel_valid;
    logic [2:0]         sel_index;
    logic [2:0]         pin_sync;
    logic [2:0]         rx_sync;
    logic               pin_in;
    logic               rx_in;
  } cpt_state_t;

  cpt_state_t           st;
  cpt_state_t           next_st;
  cpt_pkg::cpt_pick_t   pick;
  cpt_pkg::cpt_length_t rx_len;
  cpt_pkg::cpt_pin_ctrl_t pc;
  logic [15:0]          prio_used;
  logic [7:0]           req_used;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  assign prio_used = st.tx_prio;
  assign req_used  = st.tx_req;

  cpt_prio_pick #(
    .N      (NUM_BUF)
  ) cpt_prio_pick_i (
    .i_req  (req_used[NUM_BUF-1:0]),
    .i_prio (prio_used[2*NUM_BUF-1:0]),
    .o_pick (pick)
  );

  cpt_length_decode cpt_length_decode_i (
    .i_length_code (i_rx_length_code),
    .o_length      (rx_len)
  );

  always_comb begin
    pc.second_tx_source_sel = st.pin_control[cpt_pkg::BIT_SECOND_TX_SOURCE_SEL];
    pc.second_tx_pin_enable = st.pin_control[cpt_pkg::BIT_SECOND_TX_PIN_ENABLE];
    pc.recessive_drive_high = st.pin_control[cpt_pkg::BIT_RECESSIVE_DRIVE_HIGH];
    pc.rx_capture_route     = st.pin_control[cpt_pkg::BIT_RX_CAPTURE_ROUTE];
    pc.can_clock_source_sel = st.pin_control[cpt_pkg::BIT_CAN_CLOCK_SOURCE_SEL];
  end

  // ---------------------------------------------------------------
  // pin and clock muxes
  // ---------------------------------------------------------------
  assign o_can_clk = pc.can_clock_source_sel ? i_osc_clk : i_pll_clk;
  // tx is dominant low; recessive either driven high or floated
  assign o_tx_pin       = i_core_tx;
  assign o_tx_pin_oe_n  = i_core_tx & ~pc.recessive_drive_high;
  assign o_second_tx_pin = pc.second_tx_source_sel ? o_can_clk : ~i_core_tx;
  assign o_second_tx_pin_oe_n  = ~pc.second_tx_pin_enable;
  assign o_second_tx_pin_is_can = pc.second_tx_pin_enable;
  assign o_capture_unit_one_in = pc.rx_capture_route ? st.rx_in : st.pin_in;

  // ---------------------------------------------------------------
  // bus handshakes
  // ---------------------------------------------------------------
  assign o_awready = ~st.aw_held & ~st.bvalid;
  assign o_wready  = ~st.w_held & ~st.bvalid;
  assign o_arready = ~st.rvalid;
  assign o_bvalid  = st.bvalid;
  assign o_bresp   = st.bresp;
  assign o_rvalid  = st.rvalid;
  assign o_rdata   = st.rdata;
  assign o_rresp   = st.rresp;
  assign o_sel_valid = st.sel_valid;
  assign o_sel_index = st.sel_index;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic        do_write;
    logic [7:0]  waddr;
    logic [31:0] wd;
    logic [31:0] mask;
    logic [31:0] rd;
    logic [1:0]  rr;
    next_st  = st;
    do_write = 1'b0;
    waddr    = st.aw_addr;
    wd       = st.w_data;
    mask     = 32'h0;
    rd       = 32'h0;
    rr       = cpt_pkg::RESP_OKAY;

    // ---------------------------------------------------------------
    // pin inputs: three flops, change counts when stages two and three agree
    // ---------------------------------------------------------------
    next_st.pin_sync = {st.pin_sync[1:0], i_shared_port_pin};
    next_st.rx_sync  = {st.rx_sync[1:0], i_rx_msg};
    if (st.pin_sync[2] == st.pin_sync[1]) begin
      next_st.pin_in = st.pin_sync[2];
    end
    if (st.rx_sync[2] == st.rx_sync[1]) begin
      next_st.rx_in = st.rx_sync[2];
    end

    // ---------------------------------------------------------------
    // write channel capture
    // ---------------------------------------------------------------
    if (i_awvalid && o_awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = i_wdata;
      next_st.w_strb = i_wstrb;
    end
    if (next_st.aw_held && next_st.w_held) begin
      do_write        = 1'b1;
      waddr           = next_st.aw_addr;
      wd              = next_st.w_data;
      for (int b = 0; b < 4; b++) begin
        mask[8*b +: 8] = {8{next_st.w_strb[b]}};
      end
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = cpt_pkg::RESP_OKAY;
    end
    if (st.bvalid && i_bready) begin
      next_st.bvalid = 1'b0;
    end

    // ---------------------------------------------------------------
    // frame engine: a finished frame clears its request
    // ---------------------------------------------------------------
    if (i_tx_done && st.sel_valid) begin
      next_st.tx_req[st.sel_index] = 1'b0;
      next_st.sel_valid            = 1'b0;
    end

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    if (do_write) begin
      unique case (waddr)
        cpt_pkg::ADDR_PIN_CONTROL: begin
          next_st.pin_control = ((st.pin_control & ~mask[7:0]) | (wd[7:0] & mask[7:0]))
                                & cpt_pkg::PIN_CONTROL_MASK;
        end
        cpt_pkg::ADDR_TX_PRIO: begin
          next_st.tx_prio = (st.tx_prio & ~mask[15:0]) | (wd[15:0] & mask[15:0]);
        end
        cpt_pkg::ADDR_TX_REQ: begin
          next_st.tx_req = (next_st.tx_req & ~mask[7:0]) | (wd[7:0] & mask[7:0]);
        end
        cpt_pkg::ADDR_MODE: begin
          if (mask[0]) begin
            next_st.mode = wd[1:0];
          end
        end
        default: begin
          next_st.bresp = cpt_pkg::RESP_SLVERR;
        end
      endcase
    end

    // ---------------------------------------------------------------
    // selection latched at start of frame, separate from bus arbitration
    // ---------------------------------------------------------------
    if (i_sof_req && !st.sel_valid) begin
      next_st.sel_valid = pick.found;
      next_st.sel_index = pick.index;
    end

    // ---------------------------------------------------------------
    // reads
    // ---------------------------------------------------------------
    if (i_arvalid && o_arready) begin
      unique case (i_araddr)
        cpt_pkg::ADDR_PIN_CONTROL: begin
          rd = {24'h0, st.pin_control & cpt_pkg::PIN_CONTROL_MASK};
        end
        cpt_pkg::ADDR_TX_PRIO:     rd = {16'h0, st.tx_prio};
        cpt_pkg::ADDR_TX_REQ:      rd = {24'h0, st.tx_req};
        cpt_pkg::ADDR_SELECT:      rd = {27'h0, st.sel_valid, 1'b0, st.sel_index};
        cpt_pkg::ADDR_MODE:        rd = {30'h0, st.mode};
        cpt_pkg::ADDR_LENGTH: begin
          if (st.mode == cpt_pkg::MODE_ENHANCED || st.mode == cpt_pkg::MODE_FIFO) begin
            rd = {16'h0, rx_len.byte_count, 3'h0, rx_len.valid, 1'b0, i_rx_rtr,
                  2'h0, i_rx_length_code};
          end else begin
            rr = cpt_pkg::RESP_SLVERR;
          end
        end
        default: rr = cpt_pkg::RESP_SLVERR;
      endcase
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd;
      next_st.rresp  = rr;
    end else if (st.rvalid && i_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st             <= '0;
      st.pin_control <= cpt_pkg::PIN_CONTROL_RESET;
      st.mode        <= cpt_pkg::MODE_RESET;
    end else if (i_clk_en) begin
      st <= next_st;
    end
  end

endmodule // cpt_top

// File: verification/cpt_xcvr.sv
// partner: can transceiver, recessive bus pulled high
`timescale 1ns/1ns
module cpt_xcvr (
  // transmit side
  input  wire logic i_tx_pin,
  input  wire logic i_tx_pin_oe_n,
  // receive side
  output logic      o_rx_msg
);
  // released pin leaves the bus recessive
  assign o_rx_msg = i_tx_pin_oe_n ? 1'h1 : i_tx_pin;
endmodule // cpt_xcvr

// File: verification/cpt_top_sva.sv
// checker: pin, selection and read relations of the can pin block
`timescale 1ns/1ns
module cpt_top_sva (
  // clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_arst_n,
  input wire logic        i_clk_en,
  // read channel
  input wire logic [7:0]  i_araddr,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic        o_rvalid,
  // frame engine
  input wire logic        i_sof_req,
  input wire logic        i_tx_done,
  input wire logic        o_sel_valid,
  input wire logic [2:0]  o_sel_index,
  // pins and clocks
  input wire logic        i_core_tx,
  input wire logic        i_osc_clk,
  input wire logic        i_pll_clk,
  input wire logic        o_can_clk,
  input wire logic        o_tx_pin,
  input wire logic        o_tx_pin_oe_n,
  input wire logic        o_second_tx_pin
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_ar;
    i_arvalid && o_arready && i_clk_en;
  endsequence
  sequence s_ar_pin;
    i_arvalid && o_arready && i_clk_en && i_araddr == cpt_pkg::ADDR_PIN_CONTROL;
  endsequence
  sequence s_keep;
    o_sel_valid && !i_tx_done && i_clk_en;
  endsequence
  rd_answer_a: assert property (s_ar |=> o_rvalid)
    else $error("read not answered");
  pin_zero_a: assert property (s_ar_pin |=> o_rdata[3:1] == 3'h0)
    else $error("unused pin control bits not zero");
  sel_only_sof_a: assert property ($rose(o_sel_valid) |-> $past(i_sof_req))
    else $error("selection without frame request");
  sel_keep_a: assert property (s_keep |=> o_sel_valid && $stable(o_sel_index))
    else $error("selection changed before done");
  sel_drop_a: assert property (o_sel_valid && i_tx_done && i_clk_en |=> !o_sel_valid)
    else $error("selection kept after done");
  tx_follow_a: assert property (o_tx_pin == i_core_tx)
    else $error("transmit bit altered");
  tx_dom_a: assert property (!i_core_tx |-> !o_tx_pin_oe_n)
    else $error("dominant bit not driven");
  sec_src_a: assert property (o_second_tx_pin == !i_core_tx || o_second_tx_pin == o_can_clk)
    else $error("second pin source wrong");
  clk_src_a: assert property (o_can_clk == i_osc_clk || o_can_clk == i_pll_clk)
    else $error("can clock source wrong");
  sof_c: cover property (i_sof_req && !o_sel_valid ##1 o_sel_valid);
endmodule // cpt_top_sva

// File: verification/can_pin_ctrl_tx_priority_tb.sv
// testbench: register, pin and selection checks of the can pin block
`timescale 1ns/1ns
module can_pin_ctrl_tx_priority_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        i_ref_clk = 1'h0, i_arst_n = 1'h0, i_clk_en = 1'h1;
  logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, rd;
  logic [3:0]  i_wstrb = 4'hf, i_rx_length_code = 4'h0;
  logic        i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
  logic        i_arvalid = 1'h0, i_rready = 1'h0, i_sof_req = 1'h0;
  logic        i_tx_done = 1'h0, i_core_tx = 1'h1, i_rx_rtr = 1'h0;
  logic        i_osc_clk = 1'h1, i_pll_clk = 1'h0, i_shared_port_pin = 1'h0;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_sel_valid;
  logic [1:0]  o_bresp, o_rresp, rs;
  logic [2:0]  o_sel_index;
  logic        o_can_clk, o_tx_pin, o_tx_pin_oe_n, o_second_tx_pin;
  logic        o_second_tx_pin_oe_n, o_second_tx_pin_is_can, o_capture_unit_one_in;
  wire         i_rx_msg;
  int          err_count = 0, samples_checked = 0;
  logic [2:0]  order [8] = '{3'h5, 3'h2, 3'h7, 3'h3, 3'h6, 3'h1, 3'h4, 3'h0};
  always #10 i_ref_clk = ~i_ref_clk;
  cpt_top cpt_top_i (.i_ref_clk, .i_arst_n, .i_clk_en, .i_awaddr, .i_awvalid, .o_awready,
    .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_sof_req,
    .i_tx_done, .o_sel_valid, .o_sel_index, .i_core_tx, .i_rx_msg, .i_rx_length_code,
    .i_rx_rtr, .i_osc_clk, .i_pll_clk, .o_can_clk, .o_tx_pin, .o_tx_pin_oe_n,
    .o_second_tx_pin, .o_second_tx_pin_oe_n, .o_second_tx_pin_is_can,
    .i_shared_port_pin, .o_capture_unit_one_in);
  cpt_xcvr cpt_xcvr_i (.i_tx_pin(o_tx_pin), .i_tx_pin_oe_n(o_tx_pin_oe_n), .o_rx_msg(i_rx_msg));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task print_verdict;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tk;
    logic [1:0] r;
    @(posedge i_ref_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    for (int n = 0; n < 40; n++) begin
      @(negedge i_ref_clk);
      ta = i_awvalid & o_awready;
      tw = i_wvalid & o_wready;
      tk = o_bvalid;
      r = o_bresp;
      @(posedge i_ref_clk);
      if (ta) i_awvalid <= 1'h0;
      if (tw) i_wvalid <= 1'h0;
      if (tk) begin
        i_bready <= 1'h0;
        chk(r, er);
        return;
      end
    end
    err_count++;
    $display("unexpected at %0t: write timed out", $time);
    print_verdict();
  endtask
  task rdr(input logic [7:0] a);
    logic ta, tk;
    @(posedge i_ref_clk);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    for (int n = 0; n < 40; n++) begin
      @(negedge i_ref_clk);
      ta = i_arvalid & o_arready;
      tk = o_rvalid;
      rd = o_rdata;
      rs = o_rresp;
      @(posedge i_ref_clk);
      if (ta) i_arvalid <= 1'h0;
      if (tk) begin
        i_rready <= 1'h0;
        return;
      end
    end
    err_count++;
    $display("unexpected at %0t: read timed out", $time);
    print_verdict();
  endtask
  task pc(input logic [7:0] v);
    wr(cpt_pkg::ADDR_PIN_CONTROL, {24'h0, v}, cpt_pkg::RESP_OKAY);
    repeat (6) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask
  task pulse(input logic sof);
    @(posedge i_ref_clk);
    if (sof) i_sof_req <= 1'h1;
    else i_tx_done <= 1'h1;
    @(posedge i_ref_clk);
    i_sof_req <= 1'h0;
    i_tx_done <= 1'h0;
    @(negedge i_ref_clk);
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_arst_n <= 1'h1;
    rdr(cpt_pkg::ADDR_PIN_CONTROL);
    chk(rd, 32'h0);
    rdr(8'h1c);
    chk(rs, cpt_pkg::RESP_SLVERR);
    wr(8'h1c, 32'h1, cpt_pkg::RESP_SLVERR);
    pc(8'hff);
    chk(o_second_tx_pin, i_osc_clk);
    chk(o_second_tx_pin_oe_n, 1'h0);
    chk(o_tx_pin_oe_n, 1'h0);
    chk(o_can_clk, i_osc_clk);
    chk(o_capture_unit_one_in, i_rx_msg);
    rdr(cpt_pkg::ADDR_PIN_CONTROL);
    chk(rd, 32'hf1);
    pc(8'h00);
    chk(o_tx_pin_oe_n, 1'h1);
    chk(o_second_tx_pin_oe_n, 1'h1);
    chk(o_second_tx_pin_is_can, 1'h0);
    chk(o_can_clk, i_pll_clk);
    chk(o_capture_unit_one_in, i_shared_port_pin);
    @(posedge i_ref_clk);
    i_shared_port_pin <= 1'h1;
    repeat (5) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk(o_capture_unit_one_in, 1'h1);
    pc(8'h40);
    chk(o_second_tx_pin_is_can, 1'h1);
    chk(o_second_tx_pin, 1'h0);
    @(posedge i_ref_clk);
    i_core_tx <= 1'h0;
    @(negedge i_ref_clk);
    chk(o_tx_pin_oe_n, 1'h0);
    chk(o_second_tx_pin, 1'h1);
    @(posedge i_ref_clk);
    i_core_tx <= 1'h1;
    rdr(cpt_pkg::ADDR_LENGTH);
    chk(rs, cpt_pkg::RESP_SLVERR);
    for (int m = 1; m < 3; m++) begin
      wr(cpt_pkg::ADDR_MODE, m, cpt_pkg::RESP_OKAY);
      for (int c = 0; c < 16; c++) begin
        @(posedge i_ref_clk);
        i_rx_length_code <= c[3:0];
        i_rx_rtr <= c[0];
        rdr(cpt_pkg::ADDR_LENGTH);
        chk(rs, cpt_pkg::RESP_OKAY);
        chk(rd[8], c < 9);
        chk(rd[6], c[0]);
        if (c < 9) chk(rd[3:0], c);
        chk(rd[15:12], (c < 9) ? c : 0);
      end
    end
    wr(cpt_pkg::ADDR_MODE, 32'h3, cpt_pkg::RESP_OKAY);
    rdr(cpt_pkg::ADDR_LENGTH);
    chk(rs, cpt_pkg::RESP_SLVERR);
    chk(rd, 32'h0);
    wr(cpt_pkg::ADDR_TX_PRIO, 32'h9cb4, cpt_pkg::RESP_OKAY);
    wr(cpt_pkg::ADDR_TX_REQ, 32'hff, cpt_pkg::RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
      pulse(1'h1);
      chk(o_sel_valid, 1'h1);
      chk(o_sel_index, order[k]);
      pulse(1'h0);
      chk(o_sel_valid, 1'h0);
    end
    rdr(cpt_pkg::ADDR_TX_REQ);
    chk(rd, 32'h0);
    pulse(1'h1);
    chk(o_sel_valid, 1'h0);
    wr(cpt_pkg::ADDR_TX_REQ, 32'h01, cpt_pkg::RESP_OKAY);
    pulse(1'h1);
    chk(o_sel_index, 3'h0);
    @(posedge i_ref_clk);
    i_clk_en <= 1'h0;
    pulse(1'h0);
    chk(o_sel_valid, 1'h1);
    @(posedge i_ref_clk);
    i_clk_en <= 1'h1;
    pulse(1'h0);
    chk(o_sel_valid, 1'h0);
    print_verdict();
  end
endmodule // can_pin_ctrl_tx_priority_tb
bind cpt_top cpt_top_sva cpt_top_sva_i (.i_ref_clk, .i_arst_n, .i_clk_en, .i_araddr,
  .i_arvalid, .o_arready, .o_rdata, .o_rvalid, .i_sof_req, .i_tx_done, .o_sel_valid,
  .o_sel_index, .i_core_tx, .i_osc_clk, .i_pll_clk, .o_can_clk, .o_tx_pin,
  .o_tx_pin_oe_n, .o_second_tx_pin);
